// file: design/adccd_top.sv
`include "adccd_cfg.svh"
module adccd_top
	import adccd_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_conv_clk,
	input  wire logic [8:0]  i_conv_code,
	output logic             o_converter_enable,
	output logic             o_input_buffer_enable,
	output logic      [1:0]  o_buffer_gain,
	output logic      [1:0]  o_bias_current_select,
	output logic      [3:0]  o_pin_route,
	output logic             o_battery_rail_route,
	output logic             o_temp_route
);
	logic [31:0] config_reg;   // Converter configuration
	logic [31:0] filter_reg;   // Filter and timing control
	logic [8:0]  limit_value;  // Overflow threshold
	logic        thermal_sel;  // Temperature source select
	logic [31:0] next_config_reg;
	logic [31:0] next_filter_reg;
	logic [8:0]  next_limit_value;
	logic        next_thermal_sel;
	logic        wr;           // APB write access phase
	logic        restart;      // Restart strobe
	logic        limit_flag_clear;
	logic [2:0]  clk_sync;     // Converter clock synchroniser
	logic [8:0]  code_q1;      // Code pipeline
	logic [8:0]  code_q2;
	logic [8:0]  code_q3;
	logic        conv_lvl;     // Filtered converter clock level
	logic        next_conv_lvl;
	logic        rise;
	logic        fall;
	logic        sample;
	adccd_state_t state;
	adccd_state_t next_state;
	logic [7:0]  settle_cnt;
	logic [7:0]  next_settle_cnt;
	logic        valid;
	logic        next_valid;
	logic        over;
	logic        next_over;
	logic        interrupted_flag;
	logic        next_interrupted_flag;
	logic        avg_done;
	logic [8:0]  avg_result;
	logic        src_change;
	logic [3:0]  ratio;

	assign wr = i_psel && i_penable && i_pwrite;
	assign restart = wr && i_paddr == `ADCCD_OFF_CLEAR
		&& i_pwdata[`ADCCD_CLR_RESTART];
	assign limit_flag_clear = wr && i_paddr == `ADCCD_OFF_CLEAR
		&& i_pwdata[`ADCCD_CLR_OVER];
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;

	// Register write decode
	always_comb begin
		next_config_reg = config_reg;
		next_filter_reg = filter_reg;
		next_limit_value = limit_value;
		next_thermal_sel = thermal_sel;
		if (wr) begin
			case (i_paddr)
				`ADCCD_OFF_CONFIG: next_config_reg = i_pwdata & `ADCCD_CFG_MASK;
				`ADCCD_OFF_FILTER: next_filter_reg = i_pwdata & `ADCCD_FC_MASK;
				`ADCCD_OFF_LIMIT: next_limit_value = i_pwdata[8:0];
				`ADCCD_OFF_THERMAL: next_thermal_sel = i_pwdata[`ADCCD_TH_SEL];
				default: ;
			endcase
		end
	end

	// Register storage
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			config_reg <= '0;
			filter_reg <= `ADCCD_FC_RESET;
			limit_value <= '0;
			thermal_sel <= 1'b0;
		end else begin
			config_reg <= next_config_reg;
			filter_reg <= next_filter_reg;
			limit_value <= next_limit_value;
			thermal_sel <= next_thermal_sel;
		end
	end

	// Read mux
	always_comb begin
		o_prdata = '0;
		case (i_paddr)
			`ADCCD_OFF_CONFIG: o_prdata = config_reg;
			`ADCCD_OFF_STATUS: begin
				o_prdata[`ADCCD_ST_VALID] = valid;
				o_prdata[`ADCCD_ST_OVER] = over;
				o_prdata[`ADCCD_ST_BREAK] = interrupted_flag;
				o_prdata[`ADCCD_ST_DATA_LO +: 9] = avg_result;
			end
			`ADCCD_OFF_LIMIT: o_prdata = {23'h0, limit_value};
			`ADCCD_OFF_FILTER: o_prdata = filter_reg;
			`ADCCD_OFF_THERMAL: o_prdata[`ADCCD_TH_SEL] = thermal_sel;
			default: o_prdata = '0;
		endcase
	end

	// Analog routing
	always_comb begin
		o_converter_enable = config_reg[`ADCCD_CFG_EN];
		o_input_buffer_enable = config_reg[`ADCCD_CFG_BUF];
		o_buffer_gain = config_reg[`ADCCD_CFG_GAIN_LO +: 2];
		o_bias_current_select = config_reg[`ADCCD_CFG_BIAS_LO +: 2];
		o_pin_route = '0;
		if (config_reg[`ADCCD_CFG_PIN_SEL]) begin
			case (config_reg[`ADCCD_CFG_CH_LO +: 3])
				3'h0: o_pin_route = 4'h1;
				3'h1: o_pin_route = 4'h2;
				3'h2: o_pin_route = 4'h4;
				3'h3: o_pin_route = 4'h8;
				default: o_pin_route = 4'h0;
			endcase
		end
		o_battery_rail_route = config_reg[`ADCCD_CFG_SUPPLY];
		o_temp_route = thermal_sel;
	end

	// Converter clock and code sampling, three stages
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			clk_sync <= '0;
			code_q1 <= '0;
			code_q2 <= '0;
			code_q3 <= '0;
			conv_lvl <= 1'b0;
		end else begin
			clk_sync <= {clk_sync[1:0], i_conv_clk};
			code_q1 <= i_conv_code;
			code_q2 <= code_q1;
			code_q3 <= code_q2;
			conv_lvl <= next_conv_lvl;
		end
	end

	// Edge pick: one raw code per converter clock
	always_comb begin
		// Level only moves once the second and third stages agree
		next_conv_lvl = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : conv_lvl;
		rise = next_conv_lvl && !conv_lvl;
		fall = !next_conv_lvl && conv_lvl;
		sample = (state == ADCCD_RUN)
			&& (filter_reg[`ADCCD_FC_EDGE] ? rise : fall);
		src_change = wr && (i_paddr == `ADCCD_OFF_CONFIG || i_paddr == `ADCCD_OFF_THERMAL);
		ratio = filter_reg[`ADCCD_FC_RATIO_LO +: 4];
		if (ratio < `ADCCD_RATIO_MIN || ratio > `ADCCD_RATIO_MAX) begin
			ratio = `ADCCD_RATIO_MIN;
		end
	end

	// Sequencer and flags
	always_comb begin
		next_state = state;
		next_settle_cnt = settle_cnt;
		next_valid = valid;
		next_over = over;
		next_interrupted_flag = interrupted_flag;
		case (state)
			ADCCD_OFF: begin
				next_settle_cnt = '0;
				if (o_converter_enable) begin
					next_state = ADCCD_SETTLE;
				end
			end
			ADCCD_SETTLE: begin
				if (rise) begin
					next_settle_cnt = settle_cnt + 8'h1;
				end
				if (settle_cnt >= filter_reg[`ADCCD_FC_DLY_LO +: 8]) begin
					next_state = ADCCD_RUN;
				end
			end
			ADCCD_RUN: ;
			default: next_state = ADCCD_OFF;
		endcase
		if (avg_done) begin
			next_valid = 1'b1;
			next_interrupted_flag = 1'b0;
		end
		if (src_change && state == ADCCD_RUN) begin
			next_interrupted_flag = 1'b1;
		end
		if (limit_flag_clear) begin
			next_over = 1'b0;
		end
		if (avg_done && avg_result > limit_value) begin
			next_over = 1'b1;
		end
		if (!o_converter_enable) begin
			next_state = ADCCD_OFF;
			next_valid = 1'b0;
		end
		if (restart) begin
			next_state = o_converter_enable ? ADCCD_SETTLE : ADCCD_OFF;
			next_settle_cnt = '0;
			next_valid = 1'b0;
			next_interrupted_flag = 1'b0;
		end
	end

	// Sequencer registers
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state <= ADCCD_OFF;
			settle_cnt <= '0;
			valid <= 1'b0;
			over <= 1'b0;
			interrupted_flag <= 1'b0;
		end else begin
			state <= next_state;
			settle_cnt <= next_settle_cnt;
			valid <= next_valid;
			over <= next_over;
			interrupted_flag <= next_interrupted_flag;
		end
	end

	// Down-sample averager
	adccd_capture u_capture (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_clear    (restart || state != ADCCD_RUN),
		.i_sample   (sample),
		.i_code     (code_q3),
		.i_filter_en(filter_reg[`ADCCD_FC_FILT]),
		.i_ratio    (ratio),
		.o_done     (avg_done),
		.o_result   (avg_result)
	);

	// Checks
	property p_restart_clears_valid;
		@(posedge i_core_clk) disable iff (!i_rst_n) restart |=> !valid;
	endproperty
	a_restart_clears_valid: assert property (p_restart_clears_valid)
		else $error("valid survived restart");
	property p_over_sticky;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			over && !limit_flag_clear |=> over;
	endproperty
	a_over_sticky: assert property (p_over_sticky)
		else $error("overflow dropped without clear");
	property p_over_clear;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			limit_flag_clear && !(avg_done && avg_result > limit_value) |=> !over;
	endproperty
	a_over_clear: assert property (p_over_clear)
		else $error("overflow not cleared");
	property p_over_set;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			avg_done && avg_result > limit_value |=> over;
	endproperty
	a_over_set: assert property (p_over_set)
		else $error("overflow not set");
	property p_valid_after_done;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			avg_done && o_converter_enable && !restart |=> valid;
	endproperty
	a_valid_after_done: assert property (p_valid_after_done)
		else $error("valid missing after sample");
	property p_no_sample_settling;
		@(posedge i_core_clk) disable iff (!i_rst_n) state != ADCCD_RUN |-> !sample;
	endproperty
	a_no_sample_settling: assert property (p_no_sample_settling)
		else $error("sample during settle");
	property p_route_pin7;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			config_reg[`ADCCD_CFG_PIN_SEL] && config_reg[`ADCCD_CFG_CH_LO +: 3] == 3'h0
			|-> o_pin_route == 4'h1;
	endproperty
	a_route_pin7: assert property (p_route_pin7)
		else $error("pin route wrong");
	property p_edge_sel;
		@(posedge i_core_clk) disable iff (!i_rst_n)
			sample |-> (filter_reg[`ADCCD_FC_EDGE] ? rise : fall);
	endproperty
	a_edge_sel: assert property (p_edge_sel)
		else $error("wrong capture edge");
	c_valid: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(valid));
	c_over: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(over));
	c_break: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(interrupted_flag));
endmodule

// file: design/adccd_cfg.svh
`ifndef ADCCD_CFG_SVH
`define ADCCD_CFG_SVH
// Register offsets
`define ADCCD_OFF_CONFIG    12'h004
`define ADCCD_OFF_STATUS    12'h008
`define ADCCD_OFF_LIMIT     12'h00c
`define ADCCD_OFF_CLEAR     12'h010
`define ADCCD_OFF_FILTER    12'h014
`define ADCCD_OFF_THERMAL   12'h0f0
// Config fields
`define ADCCD_CFG_EN        0
`define ADCCD_CFG_BUF       1
`define ADCCD_CFG_GAIN_LO   2
`define ADCCD_CFG_BIAS_LO   4
`define ADCCD_CFG_PIN_SEL   6
`define ADCCD_CFG_CH_LO     7
`define ADCCD_CFG_SUPPLY    10
`define ADCCD_CFG_MASK      32'h0000_07ff
// Status fields
`define ADCCD_ST_VALID      31
`define ADCCD_ST_OVER       30
`define ADCCD_ST_BREAK      29
`define ADCCD_ST_DATA_LO    7
// Clear bits
`define ADCCD_CLR_OVER      0
`define ADCCD_CLR_RESTART   1
// Filter control fields
`define ADCCD_FC_FILT       0
`define ADCCD_FC_RATIO_LO   1
`define ADCCD_FC_EDGE       5
`define ADCCD_FC_DLY_LO     6
`define ADCCD_FC_RESET      32'h0000_100d
`define ADCCD_FC_MASK       32'h0000_3fff
// Thermal select bit
`define ADCCD_TH_SEL        7
// Ratio code limits
`define ADCCD_RATIO_MIN     4'h1
`define ADCCD_RATIO_MAX     4'hc
`endif

// file: design/adccd_pkg.sv
package adccd_pkg;
	// Sequencer states
	typedef enum logic [1:0] {ADCCD_OFF, ADCCD_SETTLE, ADCCD_RUN} adccd_state_t;
	// Analog input selection
	typedef enum logic [2:0] {ADCCD_SRC_NONE, ADCCD_SRC_P7, ADCCD_SRC_P8, ADCCD_SRC_P10,
		ADCCD_SRC_P11, ADCCD_SRC_BATT, ADCCD_SRC_TEMP} adccd_src_t;
endpackage

// file: design/adccd_capture.sv
`include "adccd_cfg.svh"
// Averages captured codes over 2**ratio samples
module adccd_capture
	import adccd_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_clear,
	input  wire logic       i_sample,
	input  wire logic [8:0] i_code,
	input  wire logic       i_filter_en,
	input  wire logic [3:0] i_ratio,
	output logic            o_done,
	output logic      [8:0] o_result
);
	logic [20:0] acc;       // Running sum
	logic [12:0] cnt;       // Samples taken
	logic [20:0] next_acc;
	logic [12:0] next_cnt;
	logic        next_done;
	logic [8:0]  next_result;
	logic [12:0] last;      // Samples per result minus one, 2**ratio - 1
	logic [20:0] sum;

	// Accumulate and divide by shifting
	always_comb begin
		last = 13'(13'h1 << i_ratio) - 13'h1;
		sum = acc + 21'(i_code);
		next_acc = acc;
		next_cnt = cnt;
		next_done = 1'b0;
		next_result = o_result;
		if (i_clear) begin
			next_acc = '0;
			next_cnt = '0;
		end else if (i_sample) begin
			if (!i_filter_en) begin
				next_result = i_code;
				next_done = 1'b1;
			end else if (cnt >= last) begin
				next_result = 9'(sum >> i_ratio);
				next_done = 1'b1;
				next_acc = '0;
				next_cnt = '0;
			end else begin
				next_acc = sum;
				next_cnt = cnt + 13'h1;
			end
		end
	end

	// Register stage
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			acc <= '0;
			cnt <= '0;
			o_done <= 1'b0;
			o_result <= '0;
		end else begin
			acc <= next_acc;
			cnt <= next_cnt;
			o_done <= next_done;
			o_result <= next_result;
		end
	end
endmodule

// file: tb/adccd_conv_model.sv
// Behavioural stand-in for the analog converter core
module adccd_conv_model (
	input  wire logic       i_enable,
	input  wire logic [3:0] i_pin_route,
	input  wire logic       i_batt,
	input  wire logic       i_temp,
	input  wire logic [8:0] i_level_fall,
	input  wire logic [8:0] i_level_rise,
	output logic            o_conv_clk,
	output logic      [8:0] o_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic odd; // Alternates the code between level and level plus two
	// 128 ns clock, well inside the 16 MHz ceiling; one code per period and edge
	initial begin
		o_conv_clk = 1'b0;
		o_code = 9'h000;
		odd = 1'b0;
		#3;
		forever begin
			if (i_enable && $countones({i_pin_route, i_batt, i_temp}) == 1) begin
				o_conv_clk = 1'b1;
				#32 o_code = i_level_fall + {7'h00, odd, 1'b0};
				#32 o_conv_clk = 1'b0;
				#32 o_code = i_level_rise + {7'h00, odd, 1'b0};
				odd = ~odd;
				#32;
			end else begin
				// Clock stands still; the code lines carry no usable value
				o_code = ~o_code;
				#64;
			end
		end
	end
endmodule

// file: tb/adc_control_downsample_test.sv
`include "adccd_cfg.svh"
// Self-checking bench for the converter control block
module adc_control_downsample_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;   // Core clock
	logic        rst_n = 1'b0; // Active-low reset
	logic        psel = 1'b0;  // Bus select
	logic        pen = 1'b0;   // Bus enable
	logic        pwr = 1'b0;   // Bus write
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, st, d;
	logic        pready, pslverr, cclk, en, buf_en, batt, temp;
	logic [8:0]  code, ex;
	logic [8:0]  la = 9'h000; // Level seen on falling capture edges
	logic [8:0]  lb = 9'h000; // Level seen on rising capture edges
	logic [1:0]  gain, bias;
	logic [3:0]  pin;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [11:0] offs [7] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h0f0, 12'h018};
	logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_100d, 32'h0, 32'h0};

	always #4 clk = ~clk;

	adccd_top DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_conv_clk(cclk), .i_conv_code(code),
		.o_converter_enable(en), .o_input_buffer_enable(buf_en), .o_buffer_gain(gain),
		.o_bias_current_select(bias), .o_pin_route(pin), .o_battery_rail_route(batt),
		.o_temp_route(temp));

	adccd_conv_model MDL (.i_enable(en), .i_pin_route(pin), .i_batt(batt), .i_temp(temp),
		.i_level_fall(la), .i_level_rise(lb), .o_conv_clk(cclk), .o_code(code));

	// Counts one comparison, reports a mismatch
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One bus transfer: setup, access, taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
		output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// Expected one-hot pin route for a config word
	function automatic logic [3:0] route_of(input logic [31:0] c);
		return (c[6] && !c[9]) ? 4'h1 << c[8:7] : 4'h0;
	endfunction

	// Polls status until the valid flag rises, bounded
	task automatic wv();
		int k;
		k = 0;
		do begin
			apb(1'b0, `ADCCD_OFF_STATUS, 32'h0, st);
			k++;
		end while (st[31] !== 1'b1 && k < 3000);
		chk(32'(st[31]), 32'h1);
	endtask

	// Restart with new filter settings and check the averaged or raw sample
	task automatic conv(input logic [3:0] r, input logic e, input logic f);
		la = 9'($urandom % 510);
		lb = 9'($urandom % 510);
		apb(1'b1, `ADCCD_OFF_FILTER, {18'h0, 8'($urandom % 8 + 4), e, r, f}, rd);
		apb(1'b1, `ADCCD_OFF_CLEAR, 32'h2, rd);
		apb(1'b0, `ADCCD_OFF_STATUS, 32'h0, st);
		chk(32'(st[31]), 32'h0);
		wv();
		ex = (e ? lb : la) + 9'h1;
		if (f) begin
			chk(32'(st[15:7]), 32'(ex));
		end else begin
			chk(32'(st[15:7] == ex - 9'h1 || st[15:7] == ex + 9'h1), 32'h1);
		end
		chk(32'(st[29]), 32'h0);
	endtask

	// Closing report
	task automatic print_verdict();
		$display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(32'hd4c1));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, write-only and unmapped reads
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, offs[i], 32'h0, rd);
			chk(rd, rv[i]);
		end
		chk(32'({en, buf_en, batt, temp, pin}), 32'h0);
		chk(32'({pready, pslverr}), 32'h2);
		$display("reset test done");
		// Field storage and source routing, converter held off
		for (int i = 0; i < 16; i++) begin
			d = $urandom & 32'hffff_fffe;
			d[9:7] = i[2:0];
			apb(1'b1, `ADCCD_OFF_CONFIG, d, rd);
			apb(1'b0, `ADCCD_OFF_CONFIG, 32'h0, rd);
			chk(rd, d & 32'h7ff);
			chk(32'({buf_en, gain, bias, batt, pin}),
				32'({d[1], d[3:2], d[5:4], d[10], route_of(d)}));
			apb(1'b1, `ADCCD_OFF_THERMAL, d, rd);
			apb(1'b0, `ADCCD_OFF_THERMAL, 32'h0, rd);
			chk(rd | 32'(temp), (d & 32'h80) | 32'(d[7]));
			apb(1'b1, `ADCCD_OFF_LIMIT, d, rd);
			apb(1'b0, `ADCCD_OFF_LIMIT, 32'h0, rd);
			chk(rd, d & 32'h1ff);
		end
		apb(1'b1, `ADCCD_OFF_THERMAL, 32'h0, rd);
		$display("register test done");
		// Bring-up in the prescribed order
		apb(1'b1, `ADCCD_OFF_CONFIG, 32'h1, rd);
		repeat (6250) @(posedge clk);
		apb(1'b1, `ADCCD_OFF_CLEAR, 32'h2, rd);
		apb(1'b1, `ADCCD_OFF_CONFIG, 32'h41, rd);
		apb(1'b1, `ADCCD_OFF_CONFIG, 32'h43, rd);
		for (int r = 0; r < 7; r++) conv(4'(r), r[0], 1'b1);
		conv(4'h3, 1'b0, 1'b0);
		conv(4'h2, 1'b1, 1'b0);
		apb(1'b1, `ADCCD_OFF_CONFIG, 32'h403, rd);
		conv(4'h2, 1'b1, 1'b1);
		apb(1'b1, `ADCCD_OFF_CONFIG, 32'h3, rd);
		apb(1'b1, `ADCCD_OFF_THERMAL, 32'h80, rd);
		conv(4'h2, 1'b0, 1'b1);
		$display("conversion test done");
		// Overflow set, sticky, immune to a zero clear, then cleared
		apb(1'b1, `ADCCD_OFF_LIMIT, 32'(ex - 9'h1), rd);
		repeat (200) @(posedge clk);
		apb(1'b0, `ADCCD_OFF_STATUS, 32'h0, st);
		chk(32'(st[30]), 32'h1);
		apb(1'b1, `ADCCD_OFF_LIMIT, 32'h1ff, rd);
		apb(1'b1, `ADCCD_OFF_CLEAR, 32'h0, rd);
		repeat (200) @(posedge clk);
		apb(1'b0, `ADCCD_OFF_STATUS, 32'h0, st);
		chk(32'(st[30]), 32'h1);
		chk(32'(st[31]), 32'h1);
		apb(1'b1, `ADCCD_OFF_CLEAR, 32'h1, rd);
		apb(1'b0, `ADCCD_OFF_STATUS, 32'h0, st);
		chk(32'(st[30]), 32'h0);
		// Source rewrite mid-run flags the interruption
		// Longest ratio first, so no fresh result clears the flag before it is read
		apb(1'b1, `ADCCD_OFF_FILTER, 32'h0000_1019, rd);
		apb(1'b1, `ADCCD_OFF_CONFIG, 32'h3, rd);
		apb(1'b0, `ADCCD_OFF_STATUS, 32'h0, st);
		chk(32'(st[29]), 32'h1);
		apb(1'b1, `ADCCD_OFF_CONFIG, 32'h0, rd);
		apb(1'b0, `ADCCD_OFF_STATUS, 32'h0, st);
		chk(32'(st[31]), 32'h0);
		$display("flag test done");
		print_verdict();
	end
endmodule
